// >>> rtl/ptme_pkg.sv
// Constants, field layouts and carrier types of the periodic timer engine.
// Assumes a 50 MHz system clock and an APB master with 32-bit data.
// Function
// (RULE1) Clear select high clears on match A; low clears on match P or overflow.
// (RULE2) Overflow clearing happens only while the period value is all zero.
// (RULE3) Clear select is ignored in PWM, single pulse and capture modes.
// (RULE4) Mode select 00 gives compare match output mode.
// (RULE5) Compare mode, clear select low: match A and match P flags both raised.
// (RULE6) Clear select high: only match A flag, never match P flag.
// (RULE7) Software must not set compare A to zero in compare match mode.
// (RULE8) Compare mode pin changes only on match A: none, low, high or toggle.
// (RULE9) Rising run bit loads the output pin with the initial level bit.
// (RULE10) Mode 11 acts as compare mode with flags but leaves the pin undriven.
// (RULE11) Mode 10 with pin function 10 produces PWM output.
// (RULE12) PWM period is the period value, zero meaning 1024; compare A is duty.
// (RULE13) Compare A at or above the period gives a constant active level.
// (RULE14) PWM mode raises match A and match P flags on their matches.
// (RULE15) PWM: initial level picks polarity, pin function forces, invert inverts.
// (RULE16) PWM counting and matching continue while the pin is forced.
// (RULE17) Mode 10 with pin function 11 selects single pulse output mode.
// (RULE18) Single pulse: timer clock pin edge sets run; run rise starts pulse.
// (RULE19) Single pulse ends on software clear or match A, which clears run.
// (RULE20) Single pulse resets the counter only on run rise; period unused.
// (RULE21) Mode 01 is capture; source bit picks pin, pin function picks edge.
// (RULE22) In capture mode the counter starts on a software run rise.
// (RULE23) Run rise zeroes the counter; run fall holds its residual value.
// (RULE24) Capture edge codes: 00 rising, 01 falling, 10 both, 11 disabled.
// (RULE25) Capture edge copies the counter into compare A and raises a flag.
// (RULE26) Counter advances by one per selected tick while running, not paused.
package ptme_pkg;

  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned SUB_CLK_HZ = 32_768;
  localparam int unsigned SUB_DIV    = SYS_CLK_HZ / SUB_CLK_HZ;
  localparam logic [10:0] SUB_DIV_LAST = 11'(SUB_DIV - 1);

  localparam logic [7:0] ADDR_CTRL0  = 8'h00;
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] ADDR_COUNT  = 8'h08;
  localparam logic [7:0] ADDR_CMPA   = 8'h0C;
  localparam logic [7:0] ADDR_PERIOD = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  localparam int unsigned CTRL0_LSB  = 3;
  localparam int unsigned FLAG_A_BIT = 0;
  localparam int unsigned FLAG_P_BIT = 1;

  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  localparam logic [1:0] PF_CODE0 = 2'h0;
  localparam logic [1:0] PF_CODE1 = 2'h1;
  localparam logic [1:0] PF_CODE2 = 2'h2;
  localparam logic [1:0] PF_CODE3 = 2'h3;

  localparam logic [2:0] CLK_DIV4     = 3'h0;
  localparam logic [2:0] CLK_SYS      = 3'h1;
  localparam logic [2:0] CLK_DIV16    = 3'h2;
  localparam logic [2:0] CLK_DIV64    = 3'h3;
  localparam logic [2:0] CLK_SUB0     = 3'h4;
  localparam logic [2:0] CLK_SUB1     = 3'h5;
  localparam logic [2:0] CLK_PIN_RISE = 3'h6;
  localparam logic [2:0] CLK_PIN_FALL = 3'h7;

  localparam logic [9:0] CNT_ZERO = 10'h000;
  localparam logic [9:0] CNT_ONE  = 10'h001;

  typedef struct packed {
    logic       pause;
    logic [2:0] clk_sel;
    logic       counter_run;
  } ptme_ctrl0_t;

  typedef struct packed {
    logic mode_select_hi;
    logic mode_select_lo;
    logic pin_function_hi;
    logic pin_function_lo;
    logic output_initial_level;
    logic output_invert;
    logic capture_source_select;
    logic counter_clear_select;
  } ptme_ctrl1_t;

endpackage

// >>> rtl/ptme_top.sv
// Periodic timer mode engine: 10-bit counter, comparators A and P, output.
// Assumes synchronous pin inputs and an APB master; registers answer at once.
`timescale 1ns/1ps

module ptme_top
  import ptme_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RSTN_IN,
  // APB slave
  input  wire logic        APB_PSEL_IN,
  input  wire logic        APB_PENABLE_IN,
  input  wire logic        APB_PWRITE_IN,
  input  wire logic [7:0]  APB_PADDR_IN,
  input  wire logic [31:0] APB_PWDATA_IN,
  output logic      [31:0] APB_PRDATA_OUT,
  output logic             APB_PREADY_OUT,
  output logic             APB_PSLVERR_OUT,
  // Timer pins
  input  wire logic        TIMER_CLOCK_PIN_IN,
  input  wire logic        CAPTURE_INPUT_PIN_IN,
  output logic             TIMER_OUTPUT_PIN_OUT,
  output logic             TIMER_OUTPUT_PIN_OE_OUT
);

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ADDR_CTRL0) || (a == ADDR_CTRL1) ||
                  (a == ADDR_COUNT) || (a == ADDR_CMPA) ||
                  (a == ADDR_PERIOD) || (a == ADDR_STATUS);
  endfunction

  function automatic logic edge_hit(input logic [1:0] code,
                                    input logic       rise,
                                    input logic       fall);
    case (code)
      PF_CODE0: edge_hit = rise;
      PF_CODE1: edge_hit = fall;
      PF_CODE2: edge_hit = rise | fall;
      default:  edge_hit = 1'b0;
    endcase
  endfunction

  ptme_ctrl0_t ctrl0;
  ptme_ctrl1_t ctrl1;
  logic [9:0]  count;
  logic [9:0]  compare_a_value;
  logic [9:0]  period_value;
  logic        match_a_flag;
  logic        match_p_flag;
  logic        run_q;
  logic        clk_pin_q;
  logic        cap_src_q;
  logic [5:0]  prescale;
  logic [10:0] sub_cnt;
  logic        cmp_level;

  logic        wr_en;
  logic        rd_setup;
  logic [31:0] read_data;
  logic [1:0]  mode;
  logic [1:0]  pin_fn;
  logic        is_cmp;
  logic        is_single;
  logic        is_cap;
  logic        run_rise;
  logic        ck_rise;
  logic        ck_fall;
  logic        cap_src;
  logic        tick;
  logic        advance;
  logic [9:0]  cnt_inc;
  logic        hit_a;
  logic        hit_p;
  logic        clear_now;
  logic        set_a;
  logic        set_p;
  logic        cap_event;
  logic        sp_trigger;
  logic        sp_stop;
  logic        pwm_active;
  logic        next_pin;
  logic        next_oe;
  logic        wr_ctrl0;
  logic        wr_ctrl1;
  logic        wr_cmpa;
  logic        wr_period;
  logic        wr_status;
  logic        next_match_a;
  logic        next_match_p;
  logic [9:0]  next_count;
  logic        next_run;
  logic [9:0]  next_compare_a;
  logic        next_cmp_level;
  logic        cap_rise;
  logic        cap_fall;

  // Bus decode
  assign wr_en    = APB_PSEL_IN & APB_PENABLE_IN & APB_PWRITE_IN;
  assign rd_setup = APB_PSEL_IN & ~APB_PENABLE_IN;
  assign APB_PREADY_OUT = APB_PSEL_IN & APB_PENABLE_IN;

  // One write strobe per writable register (COUNT has none), all qualified by the access phase
  assign wr_ctrl0  = wr_en && (APB_PADDR_IN == ADDR_CTRL0);
  assign wr_ctrl1  = wr_en && (APB_PADDR_IN == ADDR_CTRL1);
  assign wr_cmpa   = wr_en && (APB_PADDR_IN == ADDR_CMPA);
  assign wr_period = wr_en && (APB_PADDR_IN == ADDR_PERIOD);
  assign wr_status = wr_en && (APB_PADDR_IN == ADDR_STATUS);

  always_comb begin
    read_data = 32'h0000_0000;
    case (APB_PADDR_IN)
      ADDR_CTRL0:  read_data[7:CTRL0_LSB] = ctrl0;
      ADDR_CTRL1:  read_data[7:0] = ctrl1;
      ADDR_COUNT:  read_data[9:0] = count;
      ADDR_CMPA:   read_data[9:0] = compare_a_value;
      ADDR_PERIOD: read_data[9:0] = period_value;
      ADDR_STATUS: read_data[1:0] = {match_p_flag, match_a_flag};
      default:     read_data = 32'h0000_0000;
    endcase
  end

  // Read data and error are sampled in setup so they are flop-driven in access
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      APB_PRDATA_OUT  <= 32'h0000_0000;
      APB_PSLVERR_OUT <= 1'b0;
    end else if (rd_setup) begin
      APB_PRDATA_OUT  <= APB_PWRITE_IN ? 32'h0000_0000 : read_data;
      APB_PSLVERR_OUT <= ~addr_mapped(APB_PADDR_IN);
    end
  end

  // Mode decode
  // Mode changes act at once; software should stop the counter first
  assign mode      = {ctrl1.mode_select_hi, ctrl1.mode_select_lo};
  assign pin_fn    = {ctrl1.pin_function_hi, ctrl1.pin_function_lo};
  assign is_cmp    = (mode == MODE_COMPARE) || (mode == MODE_TIMER); // RULE4 RULE10
  assign is_single = (mode == MODE_PWM) && (pin_fn == PF_CODE3); // RULE17
  assign is_cap    = (mode == MODE_CAPTURE); // RULE21

  // Pin edges; pins are already synchronous to the system clock
  assign ck_rise  = TIMER_CLOCK_PIN_IN & ~clk_pin_q;
  assign ck_fall  = ~TIMER_CLOCK_PIN_IN & clk_pin_q;
  assign cap_src  = ctrl1.capture_source_select ? TIMER_CLOCK_PIN_IN
                                                : CAPTURE_INPUT_PIN_IN; // RULE21
  assign run_rise = ctrl0.counter_run & ~run_q;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      clk_pin_q <= 1'b0;
      cap_src_q <= 1'b0;
      run_q     <= 1'b0;
    end else begin
      clk_pin_q <= TIMER_CLOCK_PIN_IN;
      cap_src_q <= cap_src;
      run_q     <= ctrl0.counter_run;
    end
  end

  // Counter clock dividers
  // Free-running prescaler; every rate below the system clock is a tick
  // Both slow clock codes share one divider, so that rate is approximate
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      prescale <= 6'h00;
      sub_cnt  <= 11'h000;
    end else begin
      prescale <= prescale + 6'h01;
      sub_cnt  <= (sub_cnt == SUB_DIV_LAST) ? 11'h000 : sub_cnt + 11'h001;
    end
  end

  always_comb begin
    case (ctrl0.clk_sel)
      CLK_DIV4:     tick = (prescale[1:0] == 2'h3);
      CLK_SYS:      tick = 1'b1;
      CLK_DIV16:    tick = (prescale[3:0] == 4'hF);
      CLK_DIV64:    tick = (prescale == 6'h3F);
      CLK_SUB0:     tick = (sub_cnt == SUB_DIV_LAST);
      CLK_SUB1:     tick = (sub_cnt == SUB_DIV_LAST);
      CLK_PIN_RISE: tick = ck_rise;
      CLK_PIN_FALL: tick = ck_fall;
      default:      tick = 1'b0;
    endcase
  end

  // Comparators look at the value the counter is about to take
  assign advance = tick & ctrl0.counter_run & ~ctrl0.pause & ~run_rise; // RULE26
  assign cnt_inc = count + CNT_ONE;
  assign hit_a   = advance && (cnt_inc == compare_a_value);
  // A zero period matches at wrap, so overflow clears only then
  assign hit_p   = advance && (cnt_inc == period_value); // RULE2 RULE12

  always_comb begin
    if (is_cmp) begin
      clear_now = ctrl1.counter_clear_select ? hit_a : hit_p; // RULE1
    end else if (is_single) begin
      clear_now = 1'b0; // RULE20
    end else begin
      clear_now = hit_p; // RULE3 RULE12 RULE16
    end
  end

  always_comb begin
    next_count = count;
    if (run_rise) begin
      next_count = CNT_ZERO; // RULE23 RULE20 RULE22
    end else if (advance) begin
      next_count = clear_now ? CNT_ZERO : cnt_inc; // RULE26
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      count <= CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // Flag sources
  assign cap_rise  = cap_src & ~cap_src_q;
  assign cap_fall  = ~cap_src & cap_src_q;
  assign cap_event = is_cap && ctrl0.counter_run &&
                     edge_hit(pin_fn, cap_rise, cap_fall); // RULE24 RULE25
  assign set_a = (hit_a && !is_cap) || cap_event; // RULE5 RULE14 RULE25
  assign set_p = hit_p && !is_single &&
                 !(is_cmp && ctrl1.counter_clear_select); // RULE5 RULE6 RULE14

  // Single pulse run control
  assign sp_trigger = is_single && !ctrl0.counter_run &&
                      ((ctrl0.clk_sel == CLK_PIN_FALL) ? ck_fall
                                                       : ck_rise); // RULE18
  assign sp_stop    = is_single && hit_a; // RULE19

  // Control registers; a hardware set of run beats any clear in that cycle
  always_comb begin
    next_run = ctrl0.counter_run;
    if (wr_ctrl0) begin
      next_run = APB_PWDATA_IN[CTRL0_LSB];
    end
    if (sp_stop) begin
      next_run = 1'b0; // RULE19
    end
    if (sp_trigger) begin
      next_run = 1'b1; // RULE18
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      ctrl0 <= '0;
    end else begin
      if (wr_ctrl0) begin
        ctrl0 <= APB_PWDATA_IN[7:CTRL0_LSB];
      end
      ctrl0.counter_run <= next_run;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      ctrl1 <= '0;
    end else if (wr_ctrl1) begin
      ctrl1 <= APB_PWDATA_IN[7:0];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      period_value <= CNT_ZERO;
    end else if (wr_period) begin
      period_value <= APB_PWDATA_IN[9:0];
    end
  end

  // Capture overrides a software write landing in the same cycle
  always_comb begin
    next_compare_a = compare_a_value;
    if (cap_event) begin
      next_compare_a = count; // RULE25
    end else if (wr_cmpa) begin
      next_compare_a = APB_PWDATA_IN[9:0];
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      compare_a_value <= CNT_ZERO;
    end else begin
      compare_a_value <= next_compare_a;
    end
  end

  // Write one to clear; a new event in the same cycle keeps the flag set
  always_comb begin
    next_match_a = set_a | match_a_flag;
    next_match_p = set_p | match_p_flag;
    if (wr_status && APB_PWDATA_IN[FLAG_A_BIT]) begin
      next_match_a = set_a;
    end
    if (wr_status && APB_PWDATA_IN[FLAG_P_BIT]) begin
      next_match_p = set_p;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      match_a_flag <= 1'b0;
      match_p_flag <= 1'b0;
    end else begin
      match_a_flag <= next_match_a;
      match_p_flag <= next_match_p;
    end
  end

  // Compare mode output level
  always_comb begin
    next_cmp_level = cmp_level;
    if (run_rise) begin
      next_cmp_level = ctrl1.output_initial_level; // RULE9
    end else if (hit_a && is_cmp) begin
      case (pin_fn) // RULE8
        PF_CODE1: next_cmp_level = 1'b0;
        PF_CODE2: next_cmp_level = 1'b1;
        PF_CODE3: next_cmp_level = ~cmp_level;
        default:  next_cmp_level = cmp_level;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      cmp_level <= 1'b0;
    end else begin
      cmp_level <= next_cmp_level;
    end
  end

  // Counter stays below the period, so duty at or above it is always on
  assign pwm_active = ctrl0.counter_run && (count < compare_a_value); // RULE13

  always_comb begin
    next_pin = cmp_level;
    if (mode == MODE_PWM) begin
      case (pin_fn) // RULE15 RULE16
        PF_CODE0: next_pin = ~ctrl1.output_initial_level;
        PF_CODE1: next_pin = ctrl1.output_initial_level;
        PF_CODE2: next_pin = pwm_active ? ctrl1.output_initial_level
                                        : ~ctrl1.output_initial_level; // RULE11
        default:  next_pin = ctrl0.counter_run ? ctrl1.output_initial_level
                                               : ~ctrl1.output_initial_level; // RULE18 RULE19
      endcase
    end
    next_pin = next_pin ^ ctrl1.output_invert; // RULE15
    next_oe  = (mode == MODE_COMPARE) || (mode == MODE_PWM); // RULE10
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      TIMER_OUTPUT_PIN_OUT    <= 1'b0;
      TIMER_OUTPUT_PIN_OE_OUT <= 1'b0;
    end else begin
      TIMER_OUTPUT_PIN_OUT    <= next_pin;
      TIMER_OUTPUT_PIN_OE_OUT <= next_oe;
    end
  end

endmodule

// >>> testbench/ptme_chk.sv
// Port checker of the timer engine: APB answer and output enable.
// Bound into every ptme_top; sees that module's ports only.
`timescale 1ns/1ps
module ptme_chk
  import ptme_pkg::*;
(
  // Clock and reset
  input wire logic        REF_CLK_IN,
  input wire logic        RSTN_IN,
  // APB
  input wire logic        APB_PSEL_IN,
  input wire logic        APB_PENABLE_IN,
  input wire logic        APB_PWRITE_IN,
  input wire logic [7:0]  APB_PADDR_IN,
  input wire logic [31:0] APB_PWDATA_IN,
  input wire logic [31:0] APB_PRDATA_OUT,
  input wire logic        APB_PREADY_OUT,
  input wire logic        APB_PSLVERR_OUT,
  // Timer output
  input wire logic        TIMER_OUTPUT_PIN_OUT,
  input wire logic        TIMER_OUTPUT_PIN_OE_OUT
);
  logic acc;
  logic hit;
  logic wr1;
  logic lo;
  assign acc = APB_PSEL_IN && APB_PENABLE_IN;
  assign hit = APB_PADDR_IN inside {ADDR_CTRL0, ADDR_CTRL1, ADDR_COUNT,
                                    ADDR_CMPA, ADDR_PERIOD, ADDR_STATUS};
  assign wr1 = acc && APB_PWRITE_IN && APB_PADDR_IN == ADDR_CTRL1;
  // Mode low bit of the last control write; OE follows it two edges on
  always_ff @(posedge REF_CLK_IN) begin
    if (wr1) begin
      lo <= APB_PWDATA_IN[6];
    end
  end
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  a_ready_access: assert property (acc |-> APB_PREADY_OUT)
    else $error("pready low in access");
  a_ready_idle: assert property (!acc |-> !APB_PREADY_OUT)
    else $error("pready high outside access");
  a_err_unmapped: assert property (acc && !hit |->
    APB_PSLVERR_OUT && APB_PRDATA_OUT == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && hit |-> !APB_PSLVERR_OUT)
    else $error("mapped access refused");
  a_write_zero: assert property (acc && APB_PWRITE_IN |->
    APB_PRDATA_OUT == 32'h0000_0000)
    else $error("read data during write");
  a_upper_zero: assert property (acc && hit |->
    APB_PRDATA_OUT[31:10] == 22'h00_0000)
    else $error("unused read bits set");
  a_oe_mode: assert property (wr1 |-> ##2 TIMER_OUTPUT_PIN_OE_OUT == !lo)
    else $error("output enable wrong for mode");
  a_reset_quiet: assert property ($rose(RSTN_IN) |->
    !TIMER_OUTPUT_PIN_OUT && !TIMER_OUTPUT_PIN_OE_OUT && !APB_PSLVERR_OUT)
    else $error("outputs not quiet after reset");
endmodule
bind ptme_top ptme_chk u_chk (.REF_CLK_IN, .RSTN_IN, .APB_PSEL_IN,
  .APB_PENABLE_IN, .APB_PWRITE_IN, .APB_PADDR_IN, .APB_PWDATA_IN,
  .APB_PRDATA_OUT, .APB_PREADY_OUT, .APB_PSLVERR_OUT,
  .TIMER_OUTPUT_PIN_OUT, .TIMER_OUTPUT_PIN_OE_OUT);

// >>> testbench/ptme_pins.sv
// Far-side model of the timer pins: external clock and capture input.
// Levels change just after a rising edge of the system clock.
`timescale 1ns/1ps
module ptme_pins (
  // System clock
  input  wire logic clk_in,
  // Pin levels
  output logic      clk_pin_out,
  output logic      cap_pin_out
);
  initial begin
    clk_pin_out = 1'b0;
    cap_pin_out = 1'b0;
  end
  // One edge on the chosen pin; a pulse is two calls
  task automatic flip(input logic cap);
    @(posedge clk_in);
    if (cap) begin
      cap_pin_out <= !cap_pin_out;
    end else begin
      clk_pin_out <= !clk_pin_out;
    end
  endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench of the timer engine through APB and its pins.
// Pin edges come from ptme_pins; stimulus lands after rising edges.
`timescale 1ns/1ps
module testbench
  import ptme_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic [31:0] rd;
  logic [31:0] h;
  logic        prdy;
  logic        perr;
  logic        er;
  logic        pin;
  logic        oe;
  logic        ckp;
  logic        cap;
  int          err_count = 0;
  int          num_checks = 0;
  always #10 clk = ~clk;
  ptme_top dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .APB_PSEL_IN(psel),
    .APB_PENABLE_IN(pen), .APB_PWRITE_IN(pwr), .APB_PADDR_IN(pa),
    .APB_PWDATA_IN(pwd), .APB_PRDATA_OUT(prd), .APB_PREADY_OUT(prdy),
    .APB_PSLVERR_OUT(perr), .TIMER_CLOCK_PIN_IN(ckp),
    .CAPTURE_INPUT_PIN_IN(cap), .TIMER_OUTPUT_PIN_OUT(pin),
    .TIMER_OUTPUT_PIN_OE_OUT(oe));
  ptme_pins pins (.clk_in(clk), .clk_pin_out(ckp), .cap_pin_out(cap));
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input string m);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e, m);
  endtask
  // Counts cycles with the output pin high
  task automatic hi(input int n);
    h = 32'h0000_0000;
    repeat (n) begin
      @(posedge clk);
      h = h + 32'(pin);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_regs;
    rchk(ADDR_CTRL1, 32'h0000_0000, "ctrl1 reset");
    rchk(ADDR_STATUS, 32'h0000_0000, "status reset");
    wr(ADDR_CMPA, 32'hFFFF_FFFF);
    rchk(ADDR_CMPA, 32'h0000_03FF, "cmpa width");
    wr(ADDR_COUNT, 32'h0000_0155);
    rchk(ADDR_COUNT, 32'h0000_0000, "count writable");
    rchk(8'h18, 32'h0000_0000, "unmapped read");
    chk(32'(er), 32'h0000_0001, "unmapped no error");
    $display("test regs done");
  endtask
  task automatic t_cmp;
    logic [31:0] mx;
    wr(ADDR_PERIOD, 32'h0000_0002);
    wr(ADDR_CMPA, 32'h0000_0005);
    wr(ADDR_CTRL1, 32'h0000_0039);
    wr(ADDR_CTRL0, 32'h0000_0018);
    repeat (3) @(posedge clk);
    chk(32'(pin), 32'h0000_0001, "initial level");
    chk(32'(oe), 32'h0000_0001, "compare mode drives");
    repeat (5) @(posedge clk);
    chk(32'(pin), 32'h0000_0000, "pin on match a");
    mx = 32'h0000_0000;
    repeat (5) begin
      bus(1'b0, ADDR_COUNT, 32'h0000_0000);
      if (rd > mx) mx = rd;
    end
    chk(mx, 32'h0000_0004, "clear on match a");
    rchk(ADDR_STATUS, 32'h0000_0001, "only flag a");
    wr(ADDR_CTRL0, 32'h0000_0010);
    bus(1'b0, ADDR_COUNT, 32'h0000_0000);
    mx = rd;
    repeat (5) @(posedge clk);
    rchk(ADDR_COUNT, mx, "count held");
    $display("test compare done");
  endtask
  task automatic t_flags;
    wr(ADDR_PERIOD, 32'h0000_0000);
    wr(ADDR_CMPA, 32'h0000_0003);
    wr(ADDR_CTRL1, 32'h0000_0028);
    wr(ADDR_STATUS, 32'h0000_0003);
    wr(ADDR_CTRL0, 32'h0000_0018);
    repeat (1100) @(posedge clk);
    rchk(ADDR_STATUS, 32'h0000_0003, "both flags");
    chk(32'(pin), 32'h0000_0001, "pin high on match");
    wr(ADDR_CTRL1, 32'h0000_00C0);
    wr(ADDR_STATUS, 32'h0000_0003);
    repeat (1100) @(posedge clk);
    chk(32'(oe), 32'h0000_0000, "mode 11 drives");
    rchk(ADDR_STATUS, 32'h0000_0003, "mode 11 flags");
    wr(ADDR_CTRL0, 32'h0000_0010);
    $display("test flags done");
  endtask
  task automatic t_pwm;
    wr(ADDR_PERIOD, 32'h0000_0004);
    wr(ADDR_CMPA, 32'h0000_0002);
    wr(ADDR_CTRL1, 32'h0000_00A9);
    wr(ADDR_CTRL0, 32'h0000_0018);
    repeat (4) @(posedge clk);
    hi(40);
    chk(h, 32'h0000_0014, "pwm duty");
    wr(ADDR_CMPA, 32'h0000_0004);
    repeat (3) @(posedge clk);
    hi(40);
    chk(h, 32'h0000_0028, "full duty");
    wr(ADDR_CTRL1, 32'h0000_00AC);
    repeat (3) @(posedge clk);
    hi(40);
    chk(h, 32'h0000_0000, "inverted");
    wr(ADDR_CTRL1, 32'h0000_0088);
    repeat (3) @(posedge clk);
    hi(20);
    chk(h, 32'h0000_0000, "forced inactive");
    wr(ADDR_CTRL1, 32'h0000_0098);
    wr(ADDR_STATUS, 32'h0000_0003);
    hi(20);
    chk(h, 32'h0000_0014, "forced active");
    rchk(ADDR_STATUS, 32'h0000_0003, "pwm flags");
    wr(ADDR_CTRL0, 32'h0000_0010);
    $display("test pwm done");
  endtask
  task automatic t_pulse;
    wr(ADDR_CMPA, 32'h0000_0006);
    wr(ADDR_CTRL1, 32'h0000_00B8);
    wr(ADDR_STATUS, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk(32'(pin), 32'h0000_0000, "pulse idle");
    pins.flip(1'b0);
    hi(30);
    chk(32'(h >= 6 && h <= 7), 32'h0000_0001, "pulse width");
    rchk(ADDR_CTRL0, 32'h0000_0010, "run not cleared");
    rchk(ADDR_STATUS, 32'h0000_0001, "pulse flags");
    pins.flip(1'b0);
    hi(10);
    chk(h, 32'h0000_0000, "falling edge fired");
    $display("test pulse done");
  endtask
  task automatic t_cap;
    wr(ADDR_PERIOD, 32'h0000_0000);
    wr(ADDR_CTRL1, 32'h0000_0040);
    wr(ADDR_CTRL0, 32'h0000_0018);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL1, 32'h0000_0040 | 32'(c << 4));
      wr(ADDR_STATUS, 32'h0000_0003);
      pins.flip(1'b1);
      repeat (5) @(posedge clk);
      rchk(ADDR_STATUS, 32'(c != 1 && c != 3), "rise capture");
      wr(ADDR_STATUS, 32'h0000_0003);
      pins.flip(1'b1);
      repeat (5) @(posedge clk);
      rchk(ADDR_STATUS, 32'(c == 1 || c == 2), "fall capture");
    end
    wr(ADDR_CMPA, 32'h0000_0000);
    wr(ADDR_CTRL1, 32'h0000_0042);
    wr(ADDR_STATUS, 32'h0000_0003);
    pins.flip(1'b0);
    repeat (5) @(posedge clk);
    rchk(ADDR_STATUS, 32'h0000_0001, "clock pin capture");
    bus(1'b0, ADDR_CMPA, 32'h0000_0000);
    chk(32'(rd != 0), 32'h0000_0001, "count not copied");
    wr(ADDR_CTRL0, 32'h0000_0098);
    bus(1'b0, ADDR_COUNT, 32'h0000_0000);
    h = rd;
    repeat (5) @(posedge clk);
    rchk(ADDR_COUNT, h, "count moved in pause");
    wr(ADDR_CTRL0, 32'h0000_0068);
    pins.flip(1'b0);
    pins.flip(1'b0);
    repeat (2) @(posedge clk);
    rchk(ADDR_COUNT, h + 32'h0000_0001, "pin clock count");
    $display("test capture done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_cmp();
    t_flags();
    t_pwm();
    t_pulse();
    t_cap();
    conclude();
  end
  // Whole run needs about 2700 cycles
  initial begin
    #400_000;
    err_count++;
    conclude();
  end
endmodule
